// >>> bench/lfd_host.sv
// Host model issuing register reads and writes
`timescale 1ns/1ns
module lfd_host
  import lfd_pkg::*;
(
  input wire logic clock_i,
  output lfd_req_type req_o
);
  initial req_o = '0;
  // One request per call; idle lines drop wr and rd and show the inverted address and data arguments
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    @(posedge clock_i);
    #1;
    req_o = {w, !w, a, d & 16'hFFCF};
    @(posedge clock_i);
    #1;
    req_o = {2'b00, ~a, ~d};
  endtask
endmodule // lfd_host

// >>> bench/lfd_regs_props.sv
// Checker for the fault status and diagnostic register group
`timescale 1ns/1ns
module lfd_regs_props
  import lfd_pkg::*;
#(
  parameter int DUTY_WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire lfd_req_type req_i,
  input wire lfd_fault_type fault_i,
  input wire logic [4:0] live_state_code_i,
  input wire logic [DUTY_WIDTH-1:0] pwm_in_duty_i,
  input wire logic [DUTY_WIDTH-1:0] pwm_out_duty_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Live inputs must settle through the input staging before a read
  sequence s_sf_steady; $stable(fault_i.string_fault)[*4]; endsequence
  sequence s_st_steady; $stable(live_state_code_i)[*4]; endsequence
  property p_rd_ans; req_i.rd |=> rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_rv; !req_i.rd |=> !rvalid_o; endproperty
  a_no_rv: assert property (p_no_rv) else $error("stray rvalid");
  property p_idle; !rvalid_o |-> rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  // Three samples cover two sync stages and the latch
  property p_set;
    (fault_i.serial_timeout || fault_i.bad_string_cfg ||
     fault_i.open_string)[*3] |=> irq_o;
  endproperty
  a_set: assert property (p_set) else $error("fault lost");
  property p_fall;
    $fell(irq_o) |-> $past(req_i.wr) && $past(req_i.addr) == LFD_OFS_STATUS;
  endproperty
  a_fall: assert property (p_fall) else $error("irq dropped");
  property p_hold; irq_o && !req_i.wr |=> irq_o; endproperty
  a_hold: assert property (p_hold) else $error("irq not held");
  property p_sf;
    s_sf_steady ##0 (req_i.rd && req_i.addr == LFD_OFS_STATUS)
      |=> rdata_o[3:0] == $past(fault_i.string_fault);
  endproperty
  a_sf: assert property (p_sf) else $error("string bits wrong");
  property p_st;
    s_st_steady ##0 (req_i.rd && req_i.addr == LFD_OFS_STATE)
      |=> rdata_o == {11'h000, $past(live_state_code_i)};
  endproperty
  a_st: assert property (p_st) else $error("state code wrong");
endmodule // lfd_regs_props

// >>> bench/testbench.sv
// Self-checking testbench for the register group
`timescale 1ns/1ns
module testbench;
  import lfd_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  lfd_req_type req;
  lfd_fault_type flt = '0;
  logic [4:0] st = '0;
  logic [15:0] pin = '0;
  logic [15:0] pout = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic irq;
  logic [15:0] expq[$];
  logic [7:0] offs[5] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1A};
  int fails = 0;
  int n_tests = 0;
  always #10 clock_i = ~clock_i;
  lfd_regs i_dut(.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req),
    .fault_i(flt), .live_state_code_i(st), .pwm_in_duty_i(pin),
    .pwm_out_duty_i(pout), .rdata_o(rdata), .rvalid_o(rvalid), .irq_o(irq));
  lfd_host i_host(.clock_i(clock_i), .req_o(req));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_irq(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t irq got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    i_host.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Each answer takes the oldest expectation; an unasked answer fails.
  // Sampled at the falling edge, mid-way through the one-cycle pulse.
  always @(negedge clock_i) begin
    if (rvalid === 1'b1) begin
      check(rdata, expq.size() ? expq.pop_front() : 'x);
    end
  end
  initial begin
    void'($urandom(16));
    tick(6);
    rstn_i = 1'b1;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    $display("test reset values done");
    for (int c = 0; c <= 19; c++) begin
      st = 5'(c);
      tick(3);
      rd(LFD_OFS_STATE, {11'h000, st});
    end
    pin = 16'($urandom);
    pout = 16'($urandom);
    tick(3);
    rd(LFD_OFS_PWM_IN, pin);
    rd(LFD_OFS_PWM_OUT, pout);
    $display("test live values done");
    // All faults, strings 2 and 4 flagged
    flt = 9'h1FA;
    tick(5);
    rd(LFD_OFS_STATUS, 16'h55CA);
    flt = 9'h00A;
    tick(4);
    rd(LFD_OFS_STATUS, 16'h54CA);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h4000);
    i_host.xfer(1'b1, LFD_OFS_STATE, 16'h7E00);
    rd(LFD_OFS_STATUS, 16'h54CA);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h6000);
    rd(LFD_OFS_STATUS, 16'h14CA);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h1800);
    rd(LFD_OFS_STATUS, 16'h04CA);
    check_irq(irq, 1'b1);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h0600);
    rd(LFD_OFS_STATUS, 16'h000A);
    check_irq(irq, 1'b0);
    $display("test fault clear done");
    // A fault still present at the clear keeps its flag; a lone clear bit
    // is ignored
    flt = 9'h100;
    tick(5);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h6000);
    i_host.xfer(1'b1, LFD_OFS_STATUS, 16'h2000);
    rd(LFD_OFS_STATUS, 16'h4000);
    check_irq(irq, 1'b1);
    $display("test set wins over clear done");
    // Reset in mid-run drops every flag and the interrupt
    flt = '0;
    rstn_i = 1'b0;
    tick(2);
    check_irq(irq, 1'b0);
    rstn_i = 1'b1;
    rd(LFD_OFS_STATUS, 16'h0000);
    $display("test mid-run reset done");
    for (int i = 0; i < 10 && expq.size() > 0; i++) tick(1);
    if (expq.size() > 0) fails++;
    give_verdict();
  end
endmodule // testbench
bind lfd_regs lfd_regs_props #(.DUTY_WIDTH(DUTY_WIDTH)) i_props(
  .clock_i(clock_i), .rstn_i(rstn_i), .req_i(req_i), .fault_i(fault_i),
  .live_state_code_i(live_state_code_i), .pwm_in_duty_i(pwm_in_duty_i),
  .pwm_out_duty_i(pwm_out_duty_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .irq_o(irq_o));

// >>> src/lfd_pkg.sv
// Package with register map, field positions and carrier types
package lfd_pkg;
  // Register byte offsets
  localparam logic [7:0] LFD_OFS_STATUS = 8'h12;
  localparam logic [7:0] LFD_OFS_STATE = 8'h14;
  localparam logic [7:0] LFD_OFS_PWM_IN = 8'h16;
  localparam logic [7:0] LFD_OFS_PWM_OUT = 8'h18;
  // Status register field positions
  localparam int LFD_BIT_TMO_FLAG = 14;
  localparam int LFD_BIT_TMO_CLR = 13;
  localparam int LFD_BIT_CFG_FLAG = 12;
  localparam int LFD_BIT_CFG_CLR = 11;
  localparam int LFD_BIT_STR_FLAG = 10;
  localparam int LFD_BIT_STR_CLR = 9;
  localparam int LFD_BIT_GND = 8;
  localparam int LFD_BIT_SHORT = 7;
  localparam int LFD_BIT_OPEN = 6;
  localparam int LFD_STR_LSB = 0;
  localparam int LFD_NUM_STRINGS = 4;
  localparam logic [15:0] LFD_RESET_VAL = 16'h0000;
  // Live state codes
  localparam logic [4:0] LFD_ST_DISABLED = 5'h00;
  localparam logic [4:0] LFD_ST_REG_STARTUP = 5'h01;
  localparam logic [4:0] LFD_ST_FUSE_READ = 5'h02;
  localparam logic [4:0] LFD_ST_STANDBY = 5'h03;
  localparam logic [4:0] LFD_ST_CONV_FIRST = 5'h04;
  localparam logic [4:0] LFD_ST_CONV_LAST = 5'h0F;
  localparam logic [4:0] LFD_ST_NORMAL = 5'h10;
  localparam logic [4:0] LFD_ST_SHUTDOWN = 5'h11;
  localparam logic [4:0] LFD_ST_STATE_A = 5'h12;
  localparam logic [4:0] LFD_ST_ALL_FAULTED = 5'h13;
  localparam logic [4:0] LFD_ST_MAX = LFD_ST_ALL_FAULTED;

  // Raw fault events from the analog/core side
  typedef struct packed {
    logic serial_timeout;
    logic bad_string_cfg;
    logic ground_short;
    logic internal_short;
    logic open_string;
    logic [3:0] string_fault;
  } lfd_fault_type;

  // Register write/read request from the serial interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } lfd_req_type;
endpackage

// >>> src/lfd_regs.sv
// Fault status and diagnostic register group of a four-string LED driver
//
// Overview of operation
// - Latch serial timeout fault in bit 14.
// - Paired write of bits 14,13 clears timeout.
// - Latch invalid string configuration in bit 12.
// - Paired write of bits 12,11 clears config fault.
// - Bit 10 sets on ground short, internal short or open string.
// - Paired write of bits 10,9 clears it.
// - Bit 8 shows ground short, read only.
// - Bit 7 internal short, cleared with bit 10.
// - Bit 6 open string, cleared with bit 10.
// - State register bits 4:0 show live state.
// - Read-only 16-bit measured input PWM duty.
// - Read-only 16-bit configured output PWM duty.
`timescale 1ns/1ns
module lfd_regs
  import lfd_pkg::*;
#(
  parameter int DUTY_WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire lfd_req_type req_i,
  input wire lfd_fault_type fault_i,
  input wire logic [4:0] live_state_code_i,
  input wire logic [DUTY_WIDTH-1:0] pwm_in_duty_i,
  input wire logic [DUTY_WIDTH-1:0] pwm_out_duty_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic irq_o
);
  localparam int FAULT_W = $bits(lfd_fault_type);

  // Refuse any width other than 16, the width of the read port and the duty snapshots
  if (DUTY_WIDTH != 16) begin : g_bad_duty_width
    $error("lfd_regs: DUTY_WIDTH must be 16");
  end

  // Synchronised copy of the analog fault levels
  lfd_fault_type fault_sync;

  // Latched fault flags and their detail indicators
  logic tmo_flag_reg;
  logic tmo_flag_next;
  logic cfg_flag_reg;
  logic cfg_flag_next;
  logic str_flag_reg;
  logic str_flag_next;
  logic gnd_ind_reg;
  logic gnd_ind_next;
  logic short_ind_reg;
  logic short_ind_next;
  logic open_ind_reg;
  logic open_ind_next;
  logic [3:0] string_reg;
  logic [3:0] string_next;

  // Snapshots of the live diagnostics
  logic [4:0] state_reg;
  logic [4:0] state_next;
  logic [15:0] pwm_in_reg;
  logic [15:0] pwm_in_next;
  logic [15:0] pwm_out_reg;
  logic [15:0] pwm_out_next;

  // Read port and interrupt level
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic irq_reg;
  logic irq_next;

  // Write decode and the assembled status word
  logic [15:0] status_view;
  logic status_wr;
  logic tmo_clr;
  logic cfg_clr;
  logic str_clr;

  // Fault inputs come from the analog side, so synchronise them first
  lfd_sync #(
    .WIDTH(FAULT_W)
  ) u_fault_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(fault_i),
    .sync_o(fault_sync)
  );

  // Decode paired status+clear writes; a lone status or clear is ignored
  always_comb begin
    status_wr = req_i.wr && (req_i.addr == LFD_OFS_STATUS);
    tmo_clr = status_wr && req_i.wdata[LFD_BIT_TMO_FLAG]
              && req_i.wdata[LFD_BIT_TMO_CLR];
    cfg_clr = status_wr && req_i.wdata[LFD_BIT_CFG_FLAG]
              && req_i.wdata[LFD_BIT_CFG_CLR];
    str_clr = status_wr && req_i.wdata[LFD_BIT_STR_FLAG]
              && req_i.wdata[LFD_BIT_STR_CLR];
  end

  // Sticky fault flags; a new event in the clear cycle wins
  always_comb begin
    tmo_flag_next = fault_sync.serial_timeout
                    | (tmo_flag_reg & ~tmo_clr);
    cfg_flag_next = fault_sync.bad_string_cfg
                    | (cfg_flag_reg & ~cfg_clr);
    str_flag_next = fault_sync.ground_short | fault_sync.internal_short
                    | fault_sync.open_string
                    | (str_flag_reg & ~str_clr);
    gnd_ind_next = fault_sync.ground_short;
    // Short and open indicators share the combined flag's clear
    short_ind_next = fault_sync.internal_short
                     | (short_ind_reg & ~str_clr);
    open_ind_next = fault_sync.open_string
                    | (open_ind_reg & ~str_clr);
  end

  // Per-string bits are live, not latched: software sees the present state
  for (genvar s = 0; s < LFD_NUM_STRINGS; s++) begin : g_string
    assign string_next[s] = fault_sync.string_fault[s];
  end

  // Live diagnostics are sampled each cycle; values from core logic
  always_comb begin
    state_next = live_state_code_i;
    pwm_in_next = pwm_in_duty_i;
    pwm_out_next = pwm_out_duty_i;
  end

  // Status word; reserved bits 15,5,4 and the clear bits read zero
  always_comb begin
    status_view = LFD_RESET_VAL;
    status_view[LFD_BIT_TMO_FLAG] = tmo_flag_reg;
    status_view[LFD_BIT_CFG_FLAG] = cfg_flag_reg;
    status_view[LFD_BIT_STR_FLAG] = str_flag_reg;
    status_view[LFD_BIT_GND] = gnd_ind_reg;
    status_view[LFD_BIT_SHORT] = short_ind_reg;
    status_view[LFD_BIT_OPEN] = open_ind_reg;
    status_view[LFD_STR_LSB +: LFD_NUM_STRINGS] = string_reg;
  end

  // Read mux; writes to reserved bits are simply dropped
  always_comb begin
    rvalid_next = req_i.rd;
    rdata_next = LFD_RESET_VAL;
    if (req_i.rd) begin
      unique case (req_i.addr)
        LFD_OFS_STATUS: rdata_next = status_view;
        LFD_OFS_STATE: rdata_next = {11'h000, state_reg};
        LFD_OFS_PWM_IN: rdata_next = pwm_in_reg;
        LFD_OFS_PWM_OUT: rdata_next = pwm_out_reg;
        default: rdata_next = LFD_RESET_VAL;
      endcase
    end
  end

  // Interrupt level follows the OR of latched flags
  always_comb begin
    irq_next = tmo_flag_next | cfg_flag_next | str_flag_next;
  end

  // Fault flags and short/open indicators; only reset or a paired clear drops them.
  // A clear racing a still-present fault loses, so no event is missed.
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tmo_flag_reg <= 1'b0;
      cfg_flag_reg <= 1'b0;
      str_flag_reg <= 1'b0;
      gnd_ind_reg <= 1'b0;
      short_ind_reg <= 1'b0;
      open_ind_reg <= 1'b0;
      string_reg <= 4'h0;
    end else begin
      tmo_flag_reg <= tmo_flag_next;
      cfg_flag_reg <= cfg_flag_next;
      str_flag_reg <= str_flag_next;
      gnd_ind_reg <= gnd_ind_next;
      short_ind_reg <= short_ind_next;
      open_ind_reg <= open_ind_next;
      string_reg <= string_next;
    end
  end

  // Live diagnostic snapshots; reads lag the core by one cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_reg <= LFD_ST_DISABLED;
      pwm_in_reg <= 16'h0000;
      pwm_out_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      pwm_in_reg <= pwm_in_next;
      pwm_out_reg <= pwm_out_next;
    end
  end

  // Read port registers, so read data and its strobe leave a flip-flop
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_reg <= LFD_RESET_VAL;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Interrupt level register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Outputs come straight from flip-flops
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign irq_o = irq_reg;
endmodule // lfd_regs

// >>> src/lfd_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module lfd_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  // Refuse an empty vector when the block is built
  if (WIDTH < 1) begin : g_bad_width
    $error("lfd_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    stage1_next = async_i;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_o = stage2_reg;
endmodule // lfd_sync
